// File: logic/exec_pkg.sv
// Constants for the skip, swap, table read and XOR execution block.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package exec_pkg;

    localparam int DATA_W = 8;
    localparam int PADDR_W = 13;
    localparam int PWORD_W = 16;
    localparam int DADDR_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int PAGE_W = PADDR_W - DATA_W;

    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 5'h1F;
    localparam logic [PADDR_W-1:0] PC_RESET = 13'h0000;

    // Opcode selection supplied by the decoder in front of this block
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_NIBBLE_SWAP_TO_REG = 4'h1,
        OP_SKIP_IF_ZERO = 4'h2,
        OP_SKIP_IF_ZERO_MOVE = 4'h3,
        OP_SKIP_IF_BIT_CLEAR = 4'h4,
        OP_TABLE_READ_SPECIFIC_PAGE = 4'h5,
        OP_TABLE_READ_CURRENT_PAGE = 4'h6,
        OP_TABLE_READ_LAST_PAGE = 4'h7,
        OP_XOR_TO_REG = 4'h8,
        OP_XOR_TO_MEMORY = 4'h9,
        OP_XOR_IMMEDIATE = 4'hA
    } op_t;

endpackage : exec_pkg

// File: logic/xor_unit.sv
// Bitwise XOR with zero detect.
// Assumes combinational use inside the execution block.
`timescale 1ns/100ps
module xor_unit (
    // Operands
    input wire logic [exec_pkg::DATA_W-1:0] a,
    input wire logic [exec_pkg::DATA_W-1:0] b,
    // Result
    output logic [exec_pkg::DATA_W-1:0] result,
    output logic zero
);
    always_comb begin
        result = a ^ b;
        zero = (result == exec_pkg::BYTE_ZERO);
    end
endmodule : xor_unit

// File: logic/skip_swap_table_xor_exec.sv
// Execution stage for swap, skip, table read and XOR instructions.
// Assumes a decoder presents one op with its operands per instruction cycle,
// and that data memory read data for the addressed byte is valid that cycle.
`timescale 1ns/100ps
module skip_swap_table_xor_exec (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Instruction from the decoder
    input wire logic instr_valid,
    input wire exec_pkg::op_t instr_op,
    input wire logic [exec_pkg::DADDR_W-1:0] instr_mem_addr,
    input wire logic [exec_pkg::BIT_SEL_W-1:0] instr_bit_sel,
    input wire logic [exec_pkg::DATA_W-1:0] instr_imm,
    // Data memory read of the addressed byte
    input wire logic [exec_pkg::DATA_W-1:0] dmem_rdata,
    // Table pointers and current page
    input wire logic [exec_pkg::DATA_W-1:0] table_pointer_low,
    input wire logic [exec_pkg::PAGE_W-1:0] table_pointer_high,
    input wire logic [exec_pkg::PAGE_W-1:0] current_page,
    // Program memory table port, word returned combinationally
    input wire logic [exec_pkg::PWORD_W-1:0] pmem_rdata,
    output logic [exec_pkg::PADDR_W-1:0] pmem_addr,
    // Data memory write
    output logic dmem_we,
    output logic [exec_pkg::DADDR_W-1:0] dmem_waddr,
    output logic [exec_pkg::DATA_W-1:0] dmem_wdata,
    // Core state
    output logic [exec_pkg::DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic [exec_pkg::DATA_W-1:0] table_high_byte_reg,
    output logic skip_q,
    output logic dummy_cycle,
    output logic instr_done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_EXEC,
        ST_DUMMY
    } state_t;

    state_t state_q, state_d;
    logic [exec_pkg::DATA_W-1:0] acc_q, acc_d;
    logic z_q, z_d;
    logic [exec_pkg::DATA_W-1:0] table_high_byte_reg_q, table_high_byte_reg_d;
    logic we_q, we_d;
    logic [exec_pkg::DADDR_W-1:0] waddr_q, waddr_d;
    logic [exec_pkg::DATA_W-1:0] wdata_q, wdata_d;
    logic skp_q, skp_d;
    logic dummy_q, dummy_d;
    logic done_q, done_d;
    logic [exec_pkg::PADDR_W-1:0] paddr_q;

    logic [exec_pkg::DATA_W-1:0] x_operand;
    logic [exec_pkg::DATA_W-1:0] x_result;
    logic x_zero;
    logic [exec_pkg::PADDR_W-1:0] table_addr;

    // ------------------------------------------------------------
    // XOR datapath
    // ------------------------------------------------------------
    assign x_operand = (instr_op == exec_pkg::OP_XOR_IMMEDIATE) ? instr_imm : dmem_rdata;

    xor_unit u_xor (
        .a(acc_q),
        .b(x_operand),
        .result(x_result),
        .zero(x_zero)
    );

    // ------------------------------------------------------------
    // Table address
    // ------------------------------------------------------------
    // Address is driven combinationally too, so the word returns in the same cycle
    always_comb begin
        case (instr_op)
            exec_pkg::OP_TABLE_READ_SPECIFIC_PAGE: table_addr = {table_pointer_high, table_pointer_low};
            exec_pkg::OP_TABLE_READ_CURRENT_PAGE: table_addr = {current_page, table_pointer_low};
            exec_pkg::OP_TABLE_READ_LAST_PAGE: table_addr = {exec_pkg::LAST_PAGE, table_pointer_low};
            default: table_addr = paddr_q;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Strobes default low every cycle so a write, skip or retire
    // never repeats from an earlier instruction; the data values
    // hold so the memory side sees steady address and data after
    // a write. Only the XOR forms touch the zero flag; swap, skip
    // and table reads leave it as it was.
    // While in the dummy state any presented instruction is
    // ignored: the decoder must present the skipped-to
    // instruction again once instr_done has pulsed; skip_q is high
    // in the one cycle whose request is refused.
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        z_d = z_q;
        table_high_byte_reg_d = table_high_byte_reg_q;
        we_d = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        skp_d = 1'b0;
        dummy_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            ST_EXEC: begin
                if (instr_valid) begin
                    done_d = 1'b1;
                    case (instr_op)
                        exec_pkg::OP_NIBBLE_SWAP_TO_REG: begin
                            acc_d = {dmem_rdata[3:0], dmem_rdata[7:4]};
                        end
                        exec_pkg::OP_SKIP_IF_ZERO: begin
                            skp_d = (dmem_rdata == exec_pkg::BYTE_ZERO);
                        end
                        exec_pkg::OP_SKIP_IF_ZERO_MOVE: begin
                            acc_d = dmem_rdata;
                            skp_d = (dmem_rdata == exec_pkg::BYTE_ZERO);
                        end
                        exec_pkg::OP_SKIP_IF_BIT_CLEAR: begin
                            skp_d = ~dmem_rdata[instr_bit_sel];
                        end
                        exec_pkg::OP_TABLE_READ_SPECIFIC_PAGE,
                        exec_pkg::OP_TABLE_READ_CURRENT_PAGE,
                        exec_pkg::OP_TABLE_READ_LAST_PAGE: begin
                            we_d = 1'b1;
                            waddr_d = instr_mem_addr;
                            wdata_d = pmem_rdata[exec_pkg::DATA_W-1:0];
                            table_high_byte_reg_d = pmem_rdata[exec_pkg::PWORD_W-1:exec_pkg::DATA_W];
                        end
                        exec_pkg::OP_XOR_TO_REG,
                        exec_pkg::OP_XOR_IMMEDIATE: begin
                            acc_d = x_result;
                            z_d = x_zero;
                        end
                        exec_pkg::OP_XOR_TO_MEMORY: begin
                            we_d = 1'b1;
                            waddr_d = instr_mem_addr;
                            wdata_d = x_result;
                            z_d = x_zero;
                        end
                        default: begin
                            done_d = 1'b0;
                        end
                    endcase
                    // A taken skip spends one more cycle as a dummy
                    if (skp_d) begin
                        done_d = 1'b0;
                        state_d = ST_DUMMY;
                    end
                end
            end
            ST_DUMMY: begin
                dummy_d = 1'b1;
                done_d = 1'b1;
                state_d = ST_EXEC;
            end
            default: begin
                state_d = ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset is synchronous; every registered output reads zero
    // from the first edge with rst high until a first instruction.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_EXEC;
            acc_q <= exec_pkg::BYTE_ZERO;
            z_q <= 1'b0;
            table_high_byte_reg_q <= exec_pkg::BYTE_ZERO;
            we_q <= 1'b0;
            waddr_q <= exec_pkg::BYTE_ZERO;
            wdata_q <= exec_pkg::BYTE_ZERO;
            skp_q <= 1'b0;
            dummy_q <= 1'b0;
            done_q <= 1'b0;
            paddr_q <= exec_pkg::PC_RESET;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            z_q <= z_d;
            table_high_byte_reg_q <= table_high_byte_reg_d;
            we_q <= we_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            skp_q <= skp_d;
            dummy_q <= dummy_d;
            done_q <= done_d;
            paddr_q <= table_addr;
        end
    end

    // Program address is the live table address so the word is read in the issuing cycle;
    // the registered copy only holds it steady between table reads.
    assign pmem_addr = table_addr;
    assign dmem_we = we_q;
    assign dmem_waddr = waddr_q;
    assign dmem_wdata = wdata_q;
    assign working_register = acc_q;
    assign zero_flag = z_q;
    assign table_high_byte_reg = table_high_byte_reg_q;
    assign skip_q = skp_q;
    assign dummy_cycle = dummy_q;
    assign instr_done = done_q;

endmodule : skip_swap_table_xor_exec

// File: tb/mem_model.sv
// Program and data memory model for the execution block.
// Assumes one clock; reads are combinational, writes land on the rising edge.
`timescale 1ns/100ps
module mem_model (
    // Memory ports
    input wire logic mclk,
    input wire logic [12:0] pmem_addr,
    input wire logic [7:0] dmem_raddr, dmem_waddr, dmem_wdata,
    input wire logic dmem_we,
    output logic [15:0] pmem_rdata,
    output logic [7:0] dmem_rdata
);
    logic [7:0] dmem [256];
    // High byte echoes the low pointer and low byte the page, so a wrong pick shows
    assign pmem_rdata = {pmem_addr[7:0], 3'h5, pmem_addr[12:8]};
    assign dmem_rdata = dmem[dmem_raddr];
    always @(posedge mclk) if (dmem_we) dmem[dmem_waddr] <= dmem_wdata;
endmodule : mem_model

// File: tb/exec_properties.sv
// Port checker for the execution block.
// Assumes mclk clocks everything and rst is synchronous active high.
`timescale 1ns/100ps
module exec_chk (
    // Inputs of the block
    input wire logic mclk, rst, instr_valid,
    input wire exec_pkg::op_t instr_op,
    input wire logic [7:0] instr_imm, dmem_rdata, table_pointer_low,
    input wire logic [2:0] instr_bit_sel,
    input wire logic [4:0] table_pointer_high, current_page,
    input wire logic [15:0] pmem_rdata,
    // Outputs of the block
    input wire logic [12:0] pmem_addr,
    input wire logic dmem_we, zero_flag, skip_q, dummy_cycle, instr_done,
    input wire logic [7:0] dmem_wdata, working_register, table_high_byte_reg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] rd_q, w_q, im_q;
    logic [15:0] pw_q;
    // A request in the skip cycle is refused
    wire go = instr_valid && !skip_q;
    always_ff @(posedge mclk) begin
        rd_q <= dmem_rdata;
        w_q <= working_register;
        im_q <= instr_imm;
        pw_q <= pmem_rdata;
    end
    sequence skip_tail;
        !instr_done ##1 dummy_cycle && instr_done ##1 !dummy_cycle;
    endsequence
    swap_nibbles_a: assert property (go && instr_op == 4'h1 |=>
        working_register == {rd_q[3:0], rd_q[7:4]} && $stable(zero_flag)) else $error("swap");
    skip_zero_a: assert property (go && instr_op == 4'h2 |=> skip_q == (rd_q == 8'h00))
        else $error("skip zero");
    skip_move_a: assert property (go && instr_op == 4'h3 |=>
        skip_q == (rd_q == 8'h00) && working_register == rd_q) else $error("skip move");
    bit_clear_a: assert property (go && instr_op == 4'h4 && !dmem_rdata[instr_bit_sel] |=> skip_q)
        else $error("bit skip");
    dummy_cycle_a: assert property (skip_q |-> skip_tail) else $error("dummy cycle");
    table_spec_a: assert property (go && instr_op == 4'h5 |->
        pmem_addr == {table_pointer_high, table_pointer_low}) else $error("table addr");
    table_cur_a: assert property (go && instr_op == 4'h6 |->
        pmem_addr == {current_page, table_pointer_low}) else $error("current page");
    table_last_a: assert property (go && instr_op == 4'h7 |-> pmem_addr[12:8] == 5'h1F)
        else $error("last page");
    table_data_a: assert property (go && instr_op inside {4'h5, 4'h6, 4'h7} |=>
        dmem_we && {table_high_byte_reg, dmem_wdata} == pw_q) else $error("table data");
    xor_reg_a: assert property (go && instr_op == 4'h8 |=>
        working_register == (w_q ^ rd_q) && zero_flag == (working_register == 8'h00)) else $error("xor reg");
    xor_mem_a: assert property (go && instr_op == 4'h9 |=> dmem_we && dmem_wdata == (w_q ^ rd_q) &&
        zero_flag == (dmem_wdata == 8'h00) && working_register == w_q) else $error("xor mem");
    xor_imm_a: assert property (go && instr_op == 4'hA |=> working_register == (w_q ^ im_q))
        else $error("xor imm");
endmodule : exec_chk
bind skip_swap_table_xor_exec exec_chk u_exec_chk (.*);

// File: tb/tb_top.sv
// Self-checking bench for the skip, swap, table read and XOR block.
// Assumes mem_model stands in for program and data memory.
`timescale 1ns/100ps
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    exec_pkg::op_t instr_op = exec_pkg::OP_NONE;
    logic [7:0] instr_mem_addr = 8'h00, instr_imm = 8'h00, table_pointer_low = 8'h6E, w_exp;
    logic [2:0] instr_bit_sel = 3'h0;
    logic [4:0] table_pointer_high = 5'h0A, current_page = 5'h13;
    wire logic [15:0] pmem_rdata;
    wire logic [12:0] pmem_addr;
    wire logic [7:0] dmem_rdata, dmem_waddr, dmem_wdata, working_register, table_high_byte_reg;
    wire logic dmem_we, zero_flag, skip_q, dummy_cycle, instr_done;
    int mismatches = 0, checks = 0, cycles = 0;
    always #20 mclk = ~mclk;
    skip_swap_table_xor_exec u_skip_swap_table_xor_exec (.*);
    mem_model u_mem_model (.mclk(mclk), .pmem_addr(pmem_addr), .dmem_raddr(instr_mem_addr), .dmem_waddr(dmem_waddr),
        .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .pmem_rdata(pmem_rdata), .dmem_rdata(dmem_rdata));
    // ----------------------------------------
    // Bench tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Valid stays up so requests can run back to back; idle drops it
    task automatic issue(input exec_pkg::op_t op, input logic [7:0] ad, input logic [7:0] im, input logic [2:0] b);
        instr_op = op;
        instr_mem_addr = ad;
        instr_imm = im;
        instr_bit_sel = b;
        instr_valid = 1'b1;
        @(negedge mclk);
    endtask : issue
    task automatic idle;
        instr_valid = 1'b0;
        @(negedge mclk);
    endtask : idle
    task automatic t_swap_xor;
        u_mem_model.dmem[8'h10] = 8'h3C;
        u_mem_model.dmem[8'h50] = 8'hFF;
        u_mem_model.dmem[8'h51] = 8'h81;
        issue(exec_pkg::OP_NIBBLE_SWAP_TO_REG, 8'h10, 8'h00, 3'h0);
        chk({dmem_we, zero_flag, working_register}, 10'h0C3);
        issue(exec_pkg::OP_XOR_IMMEDIATE, 8'h00, 8'h3C, 3'h0);
        chk({zero_flag, working_register}, 9'h0FF);
        issue(exec_pkg::OP_XOR_TO_REG, 8'h50, 8'h00, 3'h0);
        chk({zero_flag, working_register}, 9'h100);
        issue(exec_pkg::OP_XOR_IMMEDIATE, 8'h00, 8'h81, 3'h0);
        chk({zero_flag, working_register}, 9'h081);
        issue(exec_pkg::OP_XOR_TO_MEMORY, 8'h51, 8'h00, 3'h0);
        chk({dmem_we, zero_flag, dmem_waddr, dmem_wdata, working_register}, {2'b11, 8'h51, 8'h00, 8'h81});
        idle();
        chk({u_mem_model.dmem[8'h10], u_mem_model.dmem[8'h51]}, 16'h3C00);
        w_exp = 8'h81;
        $display("swap and xor done");
    endtask : t_swap_xor
    task automatic t_skip(input exec_pkg::op_t op, input logic [7:0] v, input logic [2:0] b);
        logic sk;
        sk = (op == exec_pkg::OP_SKIP_IF_BIT_CLEAR) ? !v[b] : (v == 8'h00);
        u_mem_model.dmem[8'h20] = v;
        issue(op, 8'h20, 8'h00, b);
        chk({skip_q, instr_done}, {sk, !sk});
        if (op == exec_pkg::OP_SKIP_IF_ZERO_MOVE) begin
            w_exp = v;
        end
        chk(working_register, w_exp);
        if (sk) begin
            issue(exec_pkg::OP_XOR_IMMEDIATE, 8'h00, 8'hFF, 3'h0);
            chk({dummy_cycle, instr_done, zero_flag, working_register}, {3'b111, w_exp});
        end
        idle();
        $display("skip op %0d value %h done", op, v);
    endtask : t_skip
    task automatic t_table(input exec_pkg::op_t op, input logic [4:0] pg);
        issue(op, 8'h40, 8'h00, 3'h0);
        chk({dmem_we, dmem_waddr, table_high_byte_reg, dmem_wdata}, {9'h140, 8'h6E, 3'h5, pg});
        idle();
        chk(u_mem_model.dmem[8'h40], {3'h5, pg});
        $display("table op %0d done", op);
    endtask : t_table
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        chk({dmem_we, zero_flag, skip_q, dummy_cycle, instr_done, working_register, table_high_byte_reg}, 21'h000000);
        t_swap_xor();
        t_skip(exec_pkg::OP_SKIP_IF_ZERO, 8'h00, 3'h0);
        t_skip(exec_pkg::OP_SKIP_IF_ZERO, 8'h80, 3'h0);
        t_skip(exec_pkg::OP_SKIP_IF_ZERO_MOVE, 8'h00, 3'h0);
        t_skip(exec_pkg::OP_SKIP_IF_ZERO_MOVE, 8'h01, 3'h0);
        for (int b = 0; b < 8; b++) t_skip(exec_pkg::OP_SKIP_IF_BIT_CLEAR, 8'hA5, b[2:0]);
        t_table(exec_pkg::OP_TABLE_READ_SPECIFIC_PAGE, 5'h0A);
        t_table(exec_pkg::OP_TABLE_READ_CURRENT_PAGE, 5'h13);
        t_table(exec_pkg::OP_TABLE_READ_LAST_PAGE, exec_pkg::LAST_PAGE);
        close_out();
    end
endmodule : tb_top
